// >>> core/lcdp_defs.svh
// Constants of the LCD driver serial host port
// Function
// - Ignore I2C transfer on wrong select level
// - First byte after I2C address is control
// - Display bytes go to RAM at pointer
// - Only the addressed device drives acknowledge
// - I2C read address returns status byte
// - Status is 0101010 plus select level
// - Test mode status is 1111000 plus level
// - SPI receive-only, reset while enable high
// - SPI samples data on rising clock
// - SPI bytes are whole, MSB first
// - First SPI byte is subaddress, bit7 direction
// - Subaddress bits 6:5 must be 01
// - Byte after accepted subaddress is control
// - Control byte: continue flag, target select
// - Address 011100, select level, then R/W
`ifndef LCDP_DEFS_SVH
`define LCDP_DEFS_SVH

// ==========================================================
// Synchroniser order and idle levels
// ==========================================================
`define LCDP_SYNC_W      7
`define LCDP_SYNC_RST    7'h0f
`define LCDP_SI_SCL      0
`define LCDP_SI_SDA      1
`define LCDP_SI_CEN      2
`define LCDP_SI_SDI      3
`define LCDP_SI_STRAP    4
`define LCDP_SI_TEST     5
`define LCDP_SI_SPI      6

// ==========================================================
// Byte layouts and codes
// ==========================================================
`define LCDP_I2C_ADDR    6'h1c
`define LCDP_ADDR_HI     7
`define LCDP_ADDR_LO     2
`define LCDP_ADDR_SEL    1
`define LCDP_ADDR_RW     0
`define LCDP_SUB_RW      7
`define LCDP_SUB_HI      6
`define LCDP_SUB_LO      5
`define LCDP_SUB_CODE    2'h1
`define LCDP_CTRL_CO     7
`define LCDP_CTRL_RS_HI  6
`define LCDP_CTRL_RS_LO  5
`define LCDP_RS_CMD      2'h0
`define LCDP_RS_RAM      2'h1
`define LCDP_STAT_NORM   7'h2a
`define LCDP_STAT_TEST   7'h78
`define LCDP_BIT_LAST    3'h7
`define LCDP_MSB         7

`endif

// >>> core/lcdp_pkg.sv
// Types of the LCD driver serial host port
package lcdp_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_TXACK,
    ST_IGN,
    ST_SPI_SUB,
    ST_SPI_RX
  } lcdp_state_t;
endpackage

// >>> core/lcdp_sync.sv
// Two-flop synchroniser bank for asynchronous port inputs
`timescale 1ns/1ps
module lcdp_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         CLK_SYS,
  input  wire logic         RST,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  // ==========================================================
  // One two-stage chain per bit
  // ==========================================================
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        meta_r[i] <= RST_VAL[i];
        q_out[i]  <= RST_VAL[i];
      end else begin
        meta_r[i] <= d_in[i];
        q_out[i]  <= meta_r[i];
      end
    end
  end
endmodule

// >>> core/lcdp_host_port.sv
// Serial host port (I2C slave or write-only SPI) of an LCD segment driver
`timescale 1ns/1ps
`include "lcdp_defs.svh"
module lcdp_host_port (
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       SPI_SEL,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  input  wire logic       CHIP_EN_N,
  input  wire logic       SERIAL_IN_LINE,
  input  wire logic       ADDR_SELECT_STRAP,
  input  wire logic       TEST_MODE,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  output logic            BYTE_VALID,
  output logic [7:0]      BYTE_DATA,
  output logic            BYTE_IS_CTRL,
  output logic            MORE_CTRL_FLAG,
  output logic [1:0]      TARGET_SELECT,
  output logic            CMD_WR,
  output logic            RAM_WR,
  output logic            BUSY
);
  // ==========================================================
  // Input synchronisation and edge detection
  // ==========================================================
  logic [`LCDP_SYNC_W-1:0] s;
  logic scl_q_r, sda_q_r, ce_q_r;
  lcdp_sync #(.W(`LCDP_SYNC_W), .RST_VAL(`LCDP_SYNC_RST)) u_sync (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .d_in    ({SPI_SEL, TEST_MODE, ADDR_SELECT_STRAP, SERIAL_IN_LINE,
                CHIP_EN_N, SDA_IN, SCL_IN}),
    .q_out   (s)
  );
  wire logic scl_s   = s[`LCDP_SI_SCL];
  wire logic sda_s   = s[`LCDP_SI_SDA];
  wire logic ce_n_s  = s[`LCDP_SI_CEN];
  wire logic strap_s = s[`LCDP_SI_STRAP];
  wire logic spi_s   = s[`LCDP_SI_SPI];

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      ce_q_r  <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      ce_q_r  <= ce_n_s;
    end
  end

  wire logic scl_rise  = scl_s && !scl_q_r;
  wire logic scl_fall  = !scl_s && scl_q_r;
  // Data edges while clock stays high are bus conditions
  wire logic i2c_start = !spi_s && scl_s && scl_q_r && sda_q_r && !sda_s;
  wire logic i2c_stop  = !spi_s && scl_s && scl_q_r && !sda_q_r && sda_s;

  // ==========================================================
  // Shared byte assembly
  // ==========================================================
  lcdp_pkg::lcdp_state_t st_r;
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic       oe_r;
  logic       rw_r;
  logic       ctrl_exp_r;
  logic       more_r;
  logic [1:0] tgt_r;

  wire logic din = spi_s ? s[`LCDP_SI_SDI] : sda_s;
  wire logic rx_st = (st_r == lcdp_pkg::ST_ADDR) || (st_r == lcdp_pkg::ST_RX) ||
                     (st_r == lcdp_pkg::ST_SPI_SUB) || (st_r == lcdp_pkg::ST_SPI_RX);
  wire logic [7:0] full_byte = {sh_r[6:0], din};
  wire logic byte_done = rx_st && scl_rise && (cnt_r == `LCDP_BIT_LAST) &&
                         !(spi_s && ce_n_s);
  wire logic data_done = byte_done &&
                         ((st_r == lcdp_pkg::ST_RX) || (st_r == lcdp_pkg::ST_SPI_RX));
  wire logic addr_ok = (full_byte[`LCDP_ADDR_HI:`LCDP_ADDR_LO] == `LCDP_I2C_ADDR) &&
                       (full_byte[`LCDP_ADDR_SEL] == strap_s);
  wire logic sub_ok  = (full_byte[`LCDP_SUB_HI:`LCDP_SUB_LO] == `LCDP_SUB_CODE) &&
                       !full_byte[`LCDP_SUB_RW];
  // Plain net, not a function: a call would miss changes of the test flag
  wire logic [6:0] stat_fix = s[`LCDP_SI_TEST] ? `LCDP_STAT_TEST : `LCDP_STAT_NORM;
  wire logic [7:0] status   = {stat_fix, strap_s};
  // Control byte clears expectation; data byte re-arms it from the continue flag
  wire logic ctrl_exp_nxt = ctrl_exp_r ? 1'b0 : more_r;
  wire logic tx_load  = !spi_s && !i2c_start && !i2c_stop && (st_r == lcdp_pkg::ST_ACK) &&
                        scl_fall && oe_r && rw_r;
  wire logic tx_shift = !spi_s && !i2c_start && !i2c_stop && (st_r == lcdp_pkg::ST_TX) &&
                        scl_fall;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sh_r <= 8'h00;
    end else if (rx_st && scl_rise) begin
      sh_r <= full_byte;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_r <= 8'h00;
    end else if (tx_load) begin
      tx_r <= status;
    end else if (tx_shift) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Transfer sequencer
  // ==========================================================
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_r       <= lcdp_pkg::ST_IDLE;
      cnt_r      <= 3'h0;
      oe_r       <= 1'b0;
      rw_r       <= 1'b0;
      ctrl_exp_r <= 1'b0;
    end else if (spi_s) begin
      oe_r <= 1'b0;
      if (ce_n_s) begin
        st_r  <= lcdp_pkg::ST_IDLE;
        cnt_r <= 3'h0;
      end else if (ce_q_r) begin
        st_r  <= lcdp_pkg::ST_SPI_SUB;
        cnt_r <= 3'h0;
      end else if (scl_rise && rx_st) begin
        cnt_r <= cnt_r + 3'h1;
        if (byte_done && st_r == lcdp_pkg::ST_SPI_SUB) begin
          st_r       <= sub_ok ? lcdp_pkg::ST_SPI_RX : lcdp_pkg::ST_IGN;
          ctrl_exp_r <= 1'b1;
        end else if (byte_done) begin
          ctrl_exp_r <= ctrl_exp_nxt;
        end
      end
    end else if (i2c_start) begin
      // Repeated start restarts the access from any state
      st_r  <= lcdp_pkg::ST_ADDR;
      cnt_r <= 3'h0;
      oe_r  <= 1'b0;
    end else if (i2c_stop) begin
      st_r <= lcdp_pkg::ST_IDLE;
      oe_r <= 1'b0;
    end else begin
      case (st_r)
        lcdp_pkg::ST_ADDR, lcdp_pkg::ST_RX: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 3'h1;
            if (byte_done && st_r == lcdp_pkg::ST_ADDR) begin
              st_r       <= addr_ok ? lcdp_pkg::ST_ACK : lcdp_pkg::ST_IGN;
              rw_r       <= full_byte[`LCDP_ADDR_RW];
              ctrl_exp_r <= 1'b1;
            end else if (byte_done) begin
              st_r       <= lcdp_pkg::ST_ACK;
              ctrl_exp_r <= ctrl_exp_nxt;
            end
          end
        end
        lcdp_pkg::ST_ACK: begin
          if (scl_fall && !oe_r) begin
            oe_r <= 1'b1;
          end else if (scl_fall && rw_r) begin
            st_r  <= lcdp_pkg::ST_TX;
            cnt_r <= 3'h0;
            oe_r  <= !status[`LCDP_MSB];
          end else if (scl_fall) begin
            st_r  <= lcdp_pkg::ST_RX;
            cnt_r <= 3'h0;
            oe_r  <= 1'b0;
          end
        end
        lcdp_pkg::ST_TX: begin
          if (scl_fall && cnt_r == `LCDP_BIT_LAST) begin
            st_r <= lcdp_pkg::ST_TXACK;
            oe_r <= 1'b0;
          end else if (scl_fall) begin
            cnt_r <= cnt_r + 3'h1;
            oe_r  <= !tx_r[6];
          end
        end
        lcdp_pkg::ST_TXACK: begin
          // Only one status byte; further clocks see a released line
          if (scl_rise) begin
            st_r <= lcdp_pkg::ST_IGN;
          end
        end
        default: begin
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Core-side byte hand-off
  // ==========================================================
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      BYTE_VALID     <= 1'b0;
      BYTE_DATA      <= 8'h00;
      BYTE_IS_CTRL   <= 1'b0;
      more_r         <= 1'b0;
      tgt_r          <= `LCDP_RS_CMD;
      CMD_WR         <= 1'b0;
      RAM_WR         <= 1'b0;
    end else begin
      BYTE_VALID <= data_done;
      CMD_WR     <= data_done && !ctrl_exp_r && (tgt_r == `LCDP_RS_CMD);
      RAM_WR     <= data_done && !ctrl_exp_r && (tgt_r == `LCDP_RS_RAM);
      if (data_done) begin
        BYTE_DATA    <= full_byte;
        BYTE_IS_CTRL <= ctrl_exp_r;
      end
      if (data_done && ctrl_exp_r) begin
        more_r <= full_byte[`LCDP_CTRL_CO];
        tgt_r  <= full_byte[`LCDP_CTRL_RS_HI:`LCDP_CTRL_RS_LO];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SDA_OUT <= 1'b0;
      SDA_OE  <= 1'b0;
      BUSY    <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
      SDA_OE  <= oe_r;
      BUSY    <= (st_r != lcdp_pkg::ST_IDLE);
    end
  end

  assign MORE_CTRL_FLAG = more_r;
  assign TARGET_SELECT  = tgt_r;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  AST_IGN_RELEASED: assert property (
    (st_r == lcdp_pkg::ST_IGN) |=> !SDA_OE) else $error("Line driven while ignoring");
  AST_ADDR_MISMATCH: assert property (
    (st_r == lcdp_pkg::ST_ADDR && byte_done && !addr_ok && !i2c_start && !i2c_stop)
      |=> st_r == lcdp_pkg::ST_IGN) else $error("Foreign address not ignored");
  AST_ACK_LOW: assert property (
    (st_r == lcdp_pkg::ST_ACK && oe_r) |=> SDA_OE) else $error("Ack not driven");
  AST_IDLE_RELEASED: assert property (
    (st_r == lcdp_pkg::ST_IDLE) [*2] |-> !SDA_OE) else $error("Idle port drives line");
  AST_CE_RESET: assert property (
    (spi_s && ce_n_s) |=> (st_r == lcdp_pkg::ST_IDLE && !oe_r))
    else $error("SPI not held in reset");
  AST_STATUS_VAL: assert property (
    tx_load |=> tx_r == {$past(s[`LCDP_SI_TEST]) ? `LCDP_STAT_TEST : `LCDP_STAT_NORM,
                         $past(strap_s)}) else $error("Wrong status byte");
  AST_SUB_REJECT: assert property (
    (spi_s && !ce_n_s && !ce_q_r && st_r == lcdp_pkg::ST_SPI_SUB && byte_done && !sub_ok)
      |=> st_r == lcdp_pkg::ST_IGN) else $error("Bad subaddress accepted");
  AST_RAM_TARGET: assert property (
    RAM_WR |-> (!BYTE_IS_CTRL && $past(tgt_r) == `LCDP_RS_RAM))
    else $error("RAM write with wrong target");
  AST_CTRL_DECODE: assert property (
    (BYTE_VALID && BYTE_IS_CTRL) |-> TARGET_SELECT == BYTE_DATA[6:5])
    else $error("Control byte not decoded");
  AST_TX_RELEASE: assert property (
    (st_r == lcdp_pkg::ST_TXACK) |=> !SDA_OE) else $error("Line held after status");

  COV_STATUS_READ: cover property (tx_load);
  COV_RAM_WRITE: cover property (RAM_WR);
  COV_SPI_ACCEPT: cover property (spi_s && st_r == lcdp_pkg::ST_SPI_RX && CMD_WR);
endmodule

// >>> tb/lcdp_host_model.sv
// Host master model: I2C master and write-only SPI sender
`timescale 1ns/1ps
module lcdp_host_model (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull,
  output logic      ce_n,
  output logic      serial_in_line
);
  // ==========================================================
  // Line timing
  // ==========================================================
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    ce_n = 1'b1;
    serial_in_line = 1'b1;
  end
  // Half of the 160 ns link period
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  // Extra cycle after the fall keeps data moves clear of clock high
  task automatic pulse(output logic s);
    half();
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic start();
    sda_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~b[i];
      pulse(s);
    end
    sda_pull = 1'b0;
    pulse(ack);
  endtask
  // Status poll ends with a not-acknowledge
  task automatic rd(output logic [7:0] b);
    logic s;
    sda_pull = 1'b0;
    for (int i = 7; i >= 0; i--) pulse(b[i]);
    pulse(s);
  endtask
  task automatic spi(input logic [7:0] b, input int n);
    logic s;
    for (int i = 7; i > 7 - n; i--) begin
      scl = 1'b0;
      serial_in_line = b[i];
      pulse(s);
    end
  endtask
  // Data line shows no stale bit across frame edges
  task automatic ce(input logic v);
    half();
    ce_n = v;
    serial_in_line = ~serial_in_line;
    half();
  endtask
endmodule

// >>> tb/lcdp_host_port_tb.sv
// Self-checking bench of the serial host port
`timescale 1ns/1ps
module lcdp_host_port_tb;
  logic        clk_sys = 1'b0;
  logic        rst;
  logic        spi_sel;
  logic        strap;
  logic        test_mode;
  logic        sda_out;
  logic        busy;
  logic        scl;
  logic        sda_pull;
  logic        ce_n;
  logic        serial_in_line;
  logic        sda_oe;
  logic        bv;
  logic        is_ctrl;
  logic        more;
  logic        cmd_wr;
  logic        ram_wr;
  logic [7:0]  bdata;
  logic [1:0]  tsel;
  logic [13:0] got[$];
  logic        a;
  logic [7:0]  rb;
  int          err_total = 0;
  int          n_compared = 0;
  logic [7:0]  wq[11] = '{8'h70, 8'h80, 8'h5a, 8'h20, 8'ha5, 8'h3c,
                          8'h70, 8'hc0, 8'h11, 8'h60, 8'h22};
  logic [13:0] xq[9] = '{14'h3080, 14'h285a, 14'h1120, 14'h05a5, 14'h053c,
                         14'h32c0, 14'h2211, 14'h1360, 14'h0322};
  // Wrong select level first, then wrong fixed bits
  logic [7:0]  bad[4] = '{8'h72, 8'h73, 8'h78, 8'h30};
  logic [7:0]  st[4] = '{8'h54, 8'h55, 8'hf0, 8'hf1};
  logic [7:0]  rej[4] = '{8'h00, 8'h40, 8'h60, 8'ha0};
  // Open-drain data line with pull-up
  wire         sda = ~(sda_pull | sda_oe);

  always #10 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (bv) got.push_back({more, is_ctrl, cmd_wr, ram_wr, tsel, bdata});

  lcdp_host_model h (
    .clk_sys  (clk_sys),
    .sda      (sda),
    .scl      (scl),
    .sda_pull (sda_pull),
    .ce_n     (ce_n),
    .serial_in_line      (serial_in_line)
  );
  lcdp_host_port i_dut (
    .CLK_SYS           (clk_sys),
    .RST               (rst),
    .SPI_SEL           (spi_sel),
    .SCL_IN            (scl),
    .SDA_IN            (sda),
    .CHIP_EN_N         (ce_n),
    .SERIAL_IN_LINE    (serial_in_line),
    .ADDR_SELECT_STRAP (strap),
    .TEST_MODE         (test_mode),
    .SDA_OUT           (sda_out),
    .SDA_OE            (sda_oe),
    .BYTE_VALID        (bv),
    .BYTE_DATA         (bdata),
    .BYTE_IS_CTRL      (is_ctrl),
    .MORE_CTRL_FLAG    (more),
    .TARGET_SELECT     (tsel),
    .CMD_WR            (cmd_wr),
    .RAM_WR            (ram_wr),
    .BUSY              (busy)
  );

  // ==========================================================
  // Checking and access tasks
  // ==========================================================
  task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic nxt(input logic [13:0] e);
    logic [13:0] s;
    s = 'x;
    if (got.size() > 0) s = got.pop_front();
    chk("byte", s, e);
  endtask
  task automatic wa(input logic [7:0] b, input logic e);
    h.wr(b, a);
    chk("ack", {13'h0, a}, {13'h0, e});
  endtask
  task automatic reset_dut();
    rst = 1'b1;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    spi_sel = 1'b0;
    strap = 1'b0;
    test_mode = 1'b0;
    reset_dut();
    h.start();
    foreach (wq[i]) begin
      if (i == 6) h.start();
      wa(wq[i], 1'b0);
    end
    chk("busy", {13'h0, busy}, 14'h1);
    h.stop();
    chk("idle", {13'h0, busy}, 14'h0);
    foreach (xq[i]) nxt(xq[i]);
    foreach (bad[i]) begin
      h.start();
      wa(bad[i], 1'b1);
      wa(8'h20, 1'b1);
      h.stop();
    end
    for (int i = 0; i < 4; i++) begin
      strap = i[0];
      test_mode = i[1];
      h.start();
      wa({6'h1c, i[0], 1'b1}, 1'b0);
      h.rd(rb);
      chk("status", {6'h0, rb}, {6'h0, st[i]});
      chk("released", {13'h0, sda_oe}, 14'h0);
      chk("sda_out", {13'h0, sda_out}, 14'h0);
      h.stop();
    end
    chk("ignored", 14'(got.size()), 14'h0);
    spi_sel = 1'b1;
    reset_dut();
    h.ce(1'b0);
    h.spi(8'h20, 8);
    for (int i = 1; i < 4; i++) h.spi(wq[i], 8);
    h.spi(8'h81, 8);
    h.ce(1'b1);
    chk("spi_idle", {13'h0, busy}, 14'h0);
    for (int i = 0; i < 3; i++) nxt(xq[i]);
    nxt(14'h0581);
    foreach (rej[i]) begin
      h.ce(1'b0);
      h.spi(rej[i], 8);
      h.spi(8'h20, 8);
      h.spi(8'h33, 8);
      h.ce(1'b1);
    end
    chk("rejected", 14'(got.size()), 14'h0);
    h.ce(1'b0);
    h.spi(8'hff, 3);
    h.ce(1'b1);
    h.ce(1'b0);
    h.spi(8'h3f, 8);
    h.spi(8'h00, 8);
    h.spi(8'h99, 8);
    h.ce(1'b1);
    nxt(14'h1000);
    nxt(14'h0899);
    chk("no_sda", {13'h0, sda_oe}, 14'h0);
    wrap_up();
  end

  // Whole run needs about 80 us, well under the 200 us limit
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule
